// ### cpu_bus_model.sv
// software side of the register port
// assumes tasks are called just after a rising edge
module cpu_bus_model (
    input  logic        clk,         // clock
    input  logic [31:0] rdata,       // read data
    output logic [31:0] addr = 0,    // address
    output logic [31:0] wdata = 0,   // data
    output logic        wr_stb = 0,  // write
    output logic        rd_stb = 0   // read
);
    timeunit 1ns; timeprecision 1ns;
    task wr(input logic [31:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d & 32'hffffffaf;
        wr_stb <= 1;
        @(posedge clk) wr_stb <= 0;
        @(posedge clk);
    endtask
    task rd(input logic [31:0] a, output logic [31:0] d);
        addr <= a;
        rd_stb <= 1;
        @(posedge clk) rd_stb <= 0;
        @(posedge clk) d = rdata;
    endtask
endmodule // cpu_bus_model

// ### timer_channel.v
// one timer channel: prescaler and 16-bit up-counter with double-buffered compare value
// assumes synchronous active-low reset already released by the top
`include "timer_run_consts.vh"
module timer_channel (
    input  wire        core_clk,      // system clock
    input  wire        rst_sync_n,    // synchronised reset
    input  wire [7:0]  run_ctrl,      // run register contents
    input  wire        idle_mode,     // chip in idle mode
    input  wire        load_wr,       // write to the compare value
    input  wire [15:0] load_data,     // compare value written
    output reg  [15:0] count_r        // counter value
);
    reg  [3:0]  presc_r;
    reg  [15:0] cmp_buf_r;
    reg  [15:0] cmp_r;
    wire        halted = idle_mode & ~run_ctrl[`BIT_IDLE_OP];
    wire        tick   = run_ctrl[`BIT_PRESCALER] & (presc_r == `PRESCALE_DIV);

    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            presc_r   <= 4'h0;
            count_r   <= 16'h0000;
            cmp_buf_r <= 16'hffff;
            cmp_r     <= 16'hffff;
        end else begin
            if (load_wr) begin
                cmp_buf_r <= load_data;
                if (!run_ctrl[`BIT_DBUF_EN])
                    cmp_r <= load_data;
            end
            if (!run_ctrl[`BIT_PRESCALER])
                presc_r <= 4'h0;
            else if (!halted)
                presc_r <= presc_r + 4'h1;
            if (!run_ctrl[`BIT_COUNTER_RUN]) begin
                count_r <= 16'h0000;
            end else if (tick && !halted) begin
                if (count_r == cmp_r) begin
                    count_r <= 16'h0000;
                    if (run_ctrl[`BIT_DBUF_EN])
                        cmp_r <= cmp_buf_r;
                end else begin
                    count_r <= count_r + 16'h0001;
                end
            end
        end
    end
endmodule // timer_channel

// ### timer_run_consts.vh
// register offsets, run-register field positions, reset values
// assumes a plain register port with byte-granular 32-bit addresses
`ifndef TIMER_RUN_CONSTS_VH
`define TIMER_RUN_CONSTS_VH

`define NUM_CHAN        7
`define CHAN_BASE_ADDR  32'hfffff1a0
`define CHAN_STRIDE     32'h00000010
`define RUN_CTRL_RESET  8'h00
`define BIT_COUNTER_RUN 0
`define BIT_PRESCALER   2
`define BIT_IDLE_OP     3
`define BIT_DBUF_EN     7
`define RUN_CTRL_MASK   8'h8d
`define PRESCALE_DIV    4'hf
`define COUNT_W         16
`define ADDR_TIMER6     32'hfffff1a0
`define ADDR_TIMER7     32'hfffff1b0
`define ADDR_TIMER8     32'hfffff1c0
`define ADDR_TIMER9     32'hfffff1d0
`define ADDR_TIMER10    32'hfffff1e0
`define ADDR_TIMER11    32'hfffff1f0
`define ADDR_TIMER12    32'hfffff200
`define ADDR_COUNT_BASE 32'hfffff300

`endif

// ### timer_run_control.v
// run-control registers for timer channels 6..12 and their counters
// assumes a single-cycle register port, read data one cycle after the strobe
`include "timer_run_consts.vh"
// Functional notes
// - bit 0 set makes the channel's 16-bit counter count while bit 2 is set, clear stops it and clears it to zero.
// - bit 7 enables double buffering of the compare value, clear writes it straight through.
// - bit 3 keeps the channel running in idle mode, clear halts it while idle.
// - bit 2 runs the channel prescaler when set and stops it when clear.
// - bits 1 and 5 read back undefined; here they read as zero.
module timer_run_control (
    input  wire        core_clk,      // system clock 100 MHz
    input  wire        rst_n,         // async active-low reset
    input  wire        idle_mode,     // chip idle mode
    input  wire [31:0] addr,          // register address
    input  wire [31:0] wdata,         // write data
    input  wire        wr_stb,        // write strobe
    input  wire        rd_stb,        // read strobe
    output reg  [31:0] rdata_r,       // read data, cycle after rd_stb
    output wire [6:0]  counter_run,   // per-channel counting
    output wire [6:0]  prescaler_run  // per-channel prescaler on
);
    localparam [31:0] CNT_BASE = `ADDR_COUNT_BASE;       // counter window base
    localparam [2:0]  NO_CHAN  = 3'h7;                   // index of no channel

    reg  [1:0]  rst_sync_r;                              // reset release pipeline
    wire        rst_sync_n = rst_sync_r[1];              // synchronised reset

    // run registers, one per channel
    reg  [7:0]  timer6_run_control_r;                    // channel 6 run register
    reg  [7:0]  timer7_run_control_r;                    // channel 7 run register
    reg  [7:0]  timer8_run_control_r;                    // channel 8 run register
    reg  [7:0]  timer9_run_control_r;                    // channel 9 run register
    reg  [7:0]  timer10_run_control_r;                   // channel 10 run register
    reg  [7:0]  timer11_run_control_r;                   // channel 11 run register
    reg  [7:0]  timer12_run_control_r;                   // channel 12 run register

    // counter values from the channels
    wire [15:0] count6_w;                                // channel 6 count
    wire [15:0] count7_w;                                // channel 7 count
    wire [15:0] count8_w;                                // channel 8 count
    wire [15:0] count9_w;                                // channel 9 count
    wire [15:0] count10_w;                               // channel 10 count
    wire [15:0] count11_w;                               // channel 11 count
    wire [15:0] count12_w;                               // channel 12 count

    wire [2:0]  run_sel;                                 // run register index
    wire [2:0]  cnt_sel;                                 // counter word index
    wire [6:0]  run_wr_en;                               // run register write enables
    wire [6:0]  load_en;                                 // compare write enables
    wire [7:0]  run_wr_val;                              // masked run register value
    reg  [7:0]  run_rd_mux;                              // selected run register
    reg  [15:0] cnt_rd_mux;                              // selected counter value
    reg  [31:0] rdata_nxt;                               // next read data

    // channel index of a run register, 7 when unmapped
    function [2:0] run_index;
        input [31:0] a;
        begin
            if (a[3:0] == 4'h0 && a >= `ADDR_TIMER6 && a <= `ADDR_TIMER12)
                run_index = a[6:4] - 3'h2;
            else
                run_index = 3'h7;
        end
    endfunction

    // channel index of a counter/compare word, 7 when unmapped
    function [2:0] cnt_index;
        input [31:0] a;
        begin
            if (a[31:8] == CNT_BASE[31:8] && a[3:0] == 4'h0 && a[7:4] < 4'h7)
                cnt_index = a[6:4];
            else
                cnt_index = 3'h7;
        end
    endfunction

    // one-hot channel select, all zero when unmapped
    function [6:0] chan_onehot;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    chan_onehot = 7'h01;
                3'h1:    chan_onehot = 7'h02;
                3'h2:    chan_onehot = 7'h04;
                3'h3:    chan_onehot = 7'h08;
                3'h4:    chan_onehot = 7'h10;
                3'h5:    chan_onehot = 7'h20;
                3'h6:    chan_onehot = 7'h40;
                default: chan_onehot = 7'h00;
            endcase
        end
    endfunction

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // address decode, shared by the write and read paths
    assign run_sel    = run_index(addr);
    assign cnt_sel    = cnt_index(addr);
    assign run_wr_en  = wr_stb ? chan_onehot(run_sel) : 7'h00;
    assign load_en    = wr_stb ? chan_onehot(cnt_sel) : 7'h00;
    assign run_wr_val = wdata[7:0] & `RUN_CTRL_MASK;

    // channel 6 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer6_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[0]) begin
            timer6_run_control_r <= run_wr_val;
        end
    end

    // channel 7 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer7_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[1]) begin
            timer7_run_control_r <= run_wr_val;
        end
    end

    // channel 8 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer8_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[2]) begin
            timer8_run_control_r <= run_wr_val;
        end
    end

    // channel 9 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer9_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[3]) begin
            timer9_run_control_r <= run_wr_val;
        end
    end

    // channel 10 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer10_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[4]) begin
            timer10_run_control_r <= run_wr_val;
        end
    end

    // channel 11 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer11_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[5]) begin
            timer11_run_control_r <= run_wr_val;
        end
    end

    // channel 12 run register
    always @(posedge core_clk) begin
        if (!rst_sync_n) begin
            timer12_run_control_r <= `RUN_CTRL_RESET;
        end else if (run_wr_en[6]) begin
            timer12_run_control_r <= run_wr_val;
        end
    end

    // run register read selection, bits 1 and 5 read as zero
    always @* begin
        case (run_sel)
            3'h0:    run_rd_mux = timer6_run_control_r;
            3'h1:    run_rd_mux = timer7_run_control_r;
            3'h2:    run_rd_mux = timer8_run_control_r;
            3'h3:    run_rd_mux = timer9_run_control_r;
            3'h4:    run_rd_mux = timer10_run_control_r;
            3'h5:    run_rd_mux = timer11_run_control_r;
            3'h6:    run_rd_mux = timer12_run_control_r;
            default: run_rd_mux = 8'h00;
        endcase
    end

    // counter value read selection
    always @* begin
        case (cnt_sel)
            3'h0:    cnt_rd_mux = count6_w;
            3'h1:    cnt_rd_mux = count7_w;
            3'h2:    cnt_rd_mux = count8_w;
            3'h3:    cnt_rd_mux = count9_w;
            3'h4:    cnt_rd_mux = count10_w;
            3'h5:    cnt_rd_mux = count11_w;
            3'h6:    cnt_rd_mux = count12_w;
            default: cnt_rd_mux = 16'h0000;
        endcase
    end

    // unmapped reads return zero
    always @* begin
        if (rd_stb && run_sel != NO_CHAN)
            rdata_nxt = {24'h000000, run_rd_mux};
        else if (rd_stb && cnt_sel != NO_CHAN)
            rdata_nxt = {16'h0000, cnt_rd_mux};
        else
            rdata_nxt = 32'h00000000;
    end

    // read data stands for the one cycle after the strobe
    always @(posedge core_clk) begin
        if (!rst_sync_n)
            rdata_r <= 32'h00000000;
        else
            rdata_r <= rdata_nxt;
    end

    // run and prescaler levels, bit 0 is channel 6
    assign counter_run[0]   = timer6_run_control_r[`BIT_COUNTER_RUN];
    assign counter_run[1]   = timer7_run_control_r[`BIT_COUNTER_RUN];
    assign counter_run[2]   = timer8_run_control_r[`BIT_COUNTER_RUN];
    assign counter_run[3]   = timer9_run_control_r[`BIT_COUNTER_RUN];
    assign counter_run[4]   = timer10_run_control_r[`BIT_COUNTER_RUN];
    assign counter_run[5]   = timer11_run_control_r[`BIT_COUNTER_RUN];
    assign counter_run[6]   = timer12_run_control_r[`BIT_COUNTER_RUN];

    assign prescaler_run[0] = timer6_run_control_r[`BIT_PRESCALER];
    assign prescaler_run[1] = timer7_run_control_r[`BIT_PRESCALER];
    assign prescaler_run[2] = timer8_run_control_r[`BIT_PRESCALER];
    assign prescaler_run[3] = timer9_run_control_r[`BIT_PRESCALER];
    assign prescaler_run[4] = timer10_run_control_r[`BIT_PRESCALER];
    assign prescaler_run[5] = timer11_run_control_r[`BIT_PRESCALER];
    assign prescaler_run[6] = timer12_run_control_r[`BIT_PRESCALER];

    // one counter per channel
    timer_channel u_chan6 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer6_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[0]),
        .load_data  (wdata[15:0]),
        .count_r    (count6_w)
    );

    timer_channel u_chan7 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer7_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[1]),
        .load_data  (wdata[15:0]),
        .count_r    (count7_w)
    );

    timer_channel u_chan8 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer8_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[2]),
        .load_data  (wdata[15:0]),
        .count_r    (count8_w)
    );

    timer_channel u_chan9 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer9_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[3]),
        .load_data  (wdata[15:0]),
        .count_r    (count9_w)
    );

    timer_channel u_chan10 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer10_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[4]),
        .load_data  (wdata[15:0]),
        .count_r    (count10_w)
    );

    timer_channel u_chan11 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer11_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[5]),
        .load_data  (wdata[15:0]),
        .count_r    (count11_w)
    );

    timer_channel u_chan12 (
        .core_clk   (core_clk),
        .rst_sync_n (rst_sync_n),
        .run_ctrl   (timer12_run_control_r),
        .idle_mode  (idle_mode),
        .load_wr    (load_en[6]),
        .load_data  (wdata[15:0]),
        .count_r    (count12_w)
    );
endmodule // timer_run_control

// ### timer_run_control_sva.sv
// assertions on the run-control register port
// assumes it is bound to the run-control top
`include "timer_run_consts.vh"
module timer_run_control_sva (
    input logic        core_clk,     // clock
    input logic        rst_n,        // reset
    input logic        idle_mode,    // idle
    input logic [31:0] addr,         // address
    input logic [31:0] wdata,        // data
    input logic        wr_stb,       // write
    input logic        rd_stb,       // read
    input logic [31:0] rdata_r,      // read data
    input logic [6:0]  counter_run,  // run
    input logic [6:0]  prescaler_run // prescaler
);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence wr_rd_s;
        wr_stb && addr == `ADDR_TIMER7 ##2 rd_stb && addr == `ADDR_TIMER7;
    endsequence
    run_bit_a: assert property (wr_stb && addr == `ADDR_TIMER6 |=> counter_run[0] == $past(wdata[0]))
        else $error("run bit");
    presc_bit_a: assert property (wr_stb && addr == `ADDR_TIMER12 |=> prescaler_run[6] == $past(wdata[2]))
        else $error("prescaler bit");
    dbuf_back_a: assert property (wr_rd_s |=> rdata_r[7] == $past(wdata[7], 3))
        else $error("buffer bit");
    idle_back_a: assert property (wr_rd_s |=> rdata_r[3] == $past(wdata[3], 3))
        else $error("idle bit");
    undef_bits_a: assert property (rd_stb && addr == `ADDR_TIMER9 |=> !rdata_r[1] && !rdata_r[5])
        else $error("undefined bits");
    reset_clear_a: assert property ($rose(rst_n) |-> counter_run == 7'h00 && prescaler_run == 7'h00)
        else $error("reset state");
endmodule // timer_run_control_sva

// ### timer_run_control_tb_top.sv
// self-checking bench for the run-control block
// assumes the bus model drives the register port
`include "timer_run_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module timer_run_control_tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic core_clk = 0, rst_n = 0, idle_mode = 0, wr_stb, rd_stb;
    logic [31:0] addr, wdata, rdata_r, d;
    logic [6:0] counter_run, prescaler_run;
    logic [7:0] ref_q [$];
    int miscompares = 0, check_count = 0, seed = 74, i;
    always #5 core_clk = ~core_clk;
    cpu_bus_model u_cpu (.clk(core_clk), .rdata(rdata_r), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
    timer_run_control u_dut (.core_clk(core_clk), .rst_n(rst_n), .idle_mode(idle_mode), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r), .counter_run(counter_run), .prescaler_run(prescaler_run));
    task conclude;
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin #100000; miscompares++; conclude; end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1;
        repeat (4) @(posedge core_clk);
        `CHK("outputs", 7'h00, counter_run | prescaler_run)
        for (i = 0; i < 7; i++) begin
            u_cpu.rd(`ADDR_TIMER6 + i * `CHAN_STRIDE, d);
            `CHK("reset", 32'h0, d)
            d = $random(seed);
            u_cpu.wr(`ADDR_TIMER6 + i * `CHAN_STRIDE, {24'h0, d[7:0]});
            ref_q.push_back(d[7:0] & 8'h8d);
        end
        for (i = 0; i < 7; i++) begin
            `CHK("cnt_run", ref_q[i][0], counter_run[i])
            `CHK("pre_run", ref_q[i][2], prescaler_run[i])
            u_cpu.rd(`ADDR_TIMER6 + i * `CHAN_STRIDE, d);
            `CHK("readback", {24'h0, ref_q[i]}, d)
        end
        u_cpu.wr(`ADDR_TIMER7, 32'h88);
        u_cpu.rd(`ADDR_TIMER7, d);
        `CHK("buf_idle", 32'h88, d)
        u_cpu.rd(`ADDR_TIMER12 + 32'h4, d);
        `CHK("unmapped", 32'h0, d)
        u_cpu.wr(`ADDR_TIMER6, 32'h00);
        u_cpu.rd(`ADDR_COUNT_BASE, d);
        `CHK("cleared", 32'h0, d)
        idle_mode <= 1;
        u_cpu.wr(`ADDR_TIMER6, 32'h05);
        repeat (40) @(posedge core_clk);
        u_cpu.rd(`ADDR_COUNT_BASE, d);
        `CHK("idle_halt", 32'h0, d)
        u_cpu.wr(`ADDR_TIMER6, 32'h0d);
        repeat (40) @(posedge core_clk);
        u_cpu.rd(`ADDR_COUNT_BASE, d);
        `CHK("idle_run", 32'h2, d)
        conclude;
    end
endmodule // timer_run_control_tb_top
bind timer_run_control timer_run_control_sva u_sva (.core_clk(core_clk), .rst_n(rst_n), .idle_mode(idle_mode),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r), .counter_run(counter_run),
    .prescaler_run(prescaler_run));
